// ### verilog/svm_pkg.sv
// shared constants and types of the supply voltage monitor control
package svm_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_GIE    = 8'h0C;
  // control register fields
  localparam int         STABLE_BIT  = 5;
  localparam int         POWER_BIT   = 4;
  localparam int         LEVEL_LSB   = 0;
  localparam int         LEVEL_W     = 4;
  localparam logic       POWER_RESET = 1'h0;
  localparam logic [3:0] LEVEL_RESET = 4'h5;
  localparam logic [3:0] LEVEL_RSVD  = 4'h0;
  localparam logic [3:0] LEVEL_EXT   = 4'hF;
  // status and mask fields
  localparam int         STAT_W      = 2;
  localparam int         LOW_BIT     = 0;
  localparam int         WAKE_BIT    = 1;
  localparam logic [1:0] MASK_RESET  = 2'h0;
  localparam int         GIE_BIT     = 0;
  // nominal comparator reference, millivolts, for documentation of taps
  localparam int         REF_MV      = 1200;

  // drive toward the analog comparator, divider and reference
  typedef struct packed {
    logic       ref_power;  // shared reference powered
    logic       det_power;  // divider and comparator powered
    logic       ext_sel;    // comparator fed from external input
    logic [3:0] level;      // divider tap select
  } svm_analog_ctl_type;

  // detector power sequence, one-hot
  typedef enum logic [2:0] {
    DET_OFF    = 3'h1,
    DET_SETTLE = 3'h2,
    DET_ACTIVE = 3'h4
  } svm_det_state_type;
endpackage : svm_pkg

// ### verilog/svm_sync3.sv
// three-stage synchroniser with agreement filter for analog levels
`timescale 1ns/10ps
`default_nettype none
module svm_sync3 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output var  logic level
);
  // all state of the synchroniser
  typedef struct packed {
    logic s1;    // metastable stage, read by s2 only
    logic s2;
    logic s3;
    logic lvl;   // accepted level
  } svm_sync_state_type;

  svm_sync_state_type st;
  svm_sync_state_type next_st;

  // accept a change only once the two settled stages agree
  always_comb begin
    next_st     = st;
    next_st.s1  = async_in;
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    if (st.s2 == st.s3) begin
      next_st.lvl = st.s3;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
endmodule : svm_sync3
`default_nettype wire

// ### verilog/svm_flag_cell.sv
// sticky status flag: hardware sets, a clear pulse resets, set wins
`timescale 1ns/10ps
`default_nettype none
module svm_flag_cell (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output var  logic flag
);
  // all state of the cell
  typedef struct packed {
    logic f;  // the flag itself
  } svm_flag_state_type;

  svm_flag_state_type st;
  svm_flag_state_type next_st;

  // an event in the clearing cycle must survive
  always_comb begin
    next_st   = st;
    next_st.f = set | (st.f & ~clr);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.f;
endmodule : svm_flag_cell
`default_nettype wire

// ### verilog/svm_monitor_ctrl.sv
// apb control and status logic of the supply voltage monitor
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - control bits 7-6 always read zero
// - stable flag read-only, set when detection reliable
// - power enable bit powers detector up/down
// - four-bit trip level select, code 0000 reserved
// - level 1111 routes external input to comparator
// - status valid only after settling interval
// - flag may be false during settling; clear it
// - stability from analog ready, not cycle count
// - no low-voltage flag before reference stable
// - shared reference restarts after both users off
// - detection runs in sleep, sets flag, wakes
// - vector taken on wake only with global enable
// - any reset returns control to powered-off state
// - flag when tap falls below reference
module svm_monitor_ctrl (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire logic                        comparator_low,
  input  wire logic                        reference_ready,
  input  wire logic                        bor_enable,
  input  wire logic                        sleep_mode,
  output var  svm_pkg::svm_analog_ctl_type analog_ctl,
  output var  logic                        irq,
  output var  logic                        wake_req,
  output var  logic                        vector_branch
);

  // all state of the controller
  typedef struct packed {
    logic                        power;    // detector power enable
    logic [3:0]                  level;    // trip level select
    logic [1:0]                  mask;     // interrupt mask
    logic                        global_irq_enable;      // global interrupt enable
    svm_pkg::svm_det_state_type  det;      // power sequence
    logic [31:0]                 rdata;    // apb read data
    logic                        rdy;      // apb ready
    logic                        err;      // apb slave error
    logic                        irq;      // interrupt level
    logic                        wake;     // wake pulse
    logic                        vect;     // vector branch pulse
    svm_pkg::svm_analog_ctl_type actl;     // analog drive
  } svm_top_state_type;

  svm_top_state_type st;
  svm_top_state_type next_st;

  // synchronised analog levels
  logic       cmp_low;   // tap below reference
  logic       ref_ok;    // reference settled

  // apb decode
  logic       xfer_done; // access phase completes this edge
  logic       wr_done;   // completed write
  logic       rd_done;   // completed read
  logic       mapped;    // address hits a register
  logic       stat_clr;  // read of status clears it

  // status flags
  logic       low_set;   // comparator event while trusted
  logic       wake_set;  // comparator event while asleep
  logic [1:0] status;    // sticky status bits
  logic       low_clr;   // status read that reported the flag
  logic       wake_clr;  // status read that reported the wake bit

  // comparator output crosses from the analog domain
  svm_sync3 u_sync_cmp (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (comparator_low),
    .level    (cmp_low)
  );

  // reference ready is an analog indication, clock independent
  svm_sync3 u_sync_ref (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (reference_ready),
    .level    (ref_ok)
  );

  // the transfer completes at the edge where pready is seen high
  assign xfer_done = psel & penable & st.rdy;
  assign wr_done   = xfer_done & pwrite;
  assign rd_done   = xfer_done & ~pwrite;
  assign mapped    = (paddr == svm_pkg::ADDR_CTRL)
                   | (paddr == svm_pkg::ADDR_STATUS)
                   | (paddr == svm_pkg::ADDR_MASK)
                   | (paddr == svm_pkg::ADDR_GIE);
  assign stat_clr  = rd_done & (paddr == svm_pkg::ADDR_STATUS);
  // clear only what the read returned; a set caught in the wait cycle survives
  assign low_clr   = stat_clr & st.rdata[svm_pkg::LOW_BIT];
  assign wake_clr  = stat_clr & st.rdata[svm_pkg::WAKE_BIT];

  // only a settled detector may raise the flag
  assign low_set  = cmp_low & (st.det == svm_pkg::DET_ACTIVE);
  assign wake_set = low_set & sleep_mode;

  // low-voltage flag, sticky until read
  svm_flag_cell u_low_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (low_set),
    .clr     (low_clr),
    .flag    (status[svm_pkg::LOW_BIT])
  );

  // wake event flag
  svm_flag_cell u_wake_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (wake_set),
    .clr     (wake_clr),
    .flag    (status[svm_pkg::WAKE_BIT])
  );

  // next-state logic: bus slave, power sequence, wake and interrupt
  always_comb begin
    next_st = st;

    // one wait state: ready rises in the second access cycle
    next_st.rdy   = psel & penable & ~st.rdy;
    next_st.err   = psel & penable & ~st.rdy & ~mapped;
    next_st.rdata = '0;
    if (psel & penable & ~st.rdy & ~pwrite) begin
      unique case (paddr)
        svm_pkg::ADDR_CTRL: begin
          // upper bits stay zero
          next_st.rdata[svm_pkg::STABLE_BIT] =
            (st.det == svm_pkg::DET_ACTIVE);
          next_st.rdata[svm_pkg::POWER_BIT] = st.power;
          next_st.rdata[svm_pkg::LEVEL_LSB +: svm_pkg::LEVEL_W] = st.level;
        end
        svm_pkg::ADDR_STATUS: begin
          next_st.rdata[svm_pkg::STAT_W-1:0] = status;
        end
        svm_pkg::ADDR_MASK: begin
          next_st.rdata[svm_pkg::STAT_W-1:0] = st.mask;
        end
        svm_pkg::ADDR_GIE: begin
          next_st.rdata[svm_pkg::GIE_BIT] = st.global_irq_enable;
        end
        default: begin
          // unmapped reads return zero with an error
          next_st.rdata = '0;
        end
      endcase
    end

    // register writes take effect at the completing edge
    if (wr_done) begin
      unique case (paddr)
        svm_pkg::ADDR_CTRL: begin
          // stable bit is read-only, writes to it are dropped
          next_st.power = pwdata[svm_pkg::POWER_BIT];
          next_st.level =
            pwdata[svm_pkg::LEVEL_LSB +: svm_pkg::LEVEL_W];
        end
        svm_pkg::ADDR_MASK: begin
          next_st.mask = pwdata[svm_pkg::STAT_W-1:0];
        end
        svm_pkg::ADDR_GIE: begin
          next_st.global_irq_enable = pwdata[svm_pkg::GIE_BIT];
        end
        default: begin
          // status is cleared by reading, writes ignored
          next_st.global_irq_enable = st.global_irq_enable;
        end
      endcase
    end

    // power sequence; stable only once the analog side says so
    unique case (st.det)
      svm_pkg::DET_OFF: begin
        if (st.power) begin
          next_st.det = svm_pkg::DET_SETTLE;
        end
      end
      svm_pkg::DET_SETTLE: begin
        if (!st.power) begin
          next_st.det = svm_pkg::DET_OFF;
        end else if (ref_ok) begin
          next_st.det = svm_pkg::DET_ACTIVE;
        end
      end
      svm_pkg::DET_ACTIVE: begin
        // reference lost, e.g. restarted, means settling again
        if (!st.power) begin
          next_st.det = svm_pkg::DET_OFF;
        end else if (!ref_ok) begin
          next_st.det = svm_pkg::DET_SETTLE;
        end
      end
      default: begin
        // illegal code recovers to powered off
        next_st.det = svm_pkg::DET_OFF;
      end
    endcase

    // analog drive; reference stays up while either user needs it
    next_st.actl.det_power = st.power;
    next_st.actl.ref_power = st.power | bor_enable;
    next_st.actl.level     = st.level;
    next_st.actl.ext_sel   = (st.level == svm_pkg::LEVEL_EXT);

    // wake on the first trusted event during sleep
    next_st.wake = wake_set & ~status[svm_pkg::LOW_BIT];
    next_st.vect = wake_set & ~status[svm_pkg::LOW_BIT]
                 & st.global_irq_enable;

    // interrupt level from unmasked sticky bits
    next_st.irq = |(status & st.mask);
  end

  // state register; reset leaves the detector off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= '0;
      st.power <= svm_pkg::POWER_RESET;
      st.level <= svm_pkg::LEVEL_RESET;
      st.mask  <= svm_pkg::MASK_RESET;
      st.det   <= svm_pkg::DET_OFF;
      st.actl  <= '{ref_power: 1'h0, det_power: 1'h0,
                    ext_sel: 1'h0, level: svm_pkg::LEVEL_RESET};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign prdata        = st.rdata;
  assign pready        = st.rdy;
  assign pslverr       = st.err;
  assign analog_ctl    = st.actl;
  assign irq           = st.irq;
  assign wake_req      = st.wake;
  assign vector_branch = st.vect;

  // checks on the controller
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // completed write to the control register
  sequence s_ctrl_write;
    wr_done && (paddr == svm_pkg::ADDR_CTRL);
  endsequence

  // control read answer presented on pready
  sequence s_ctrl_read;
    pready && psel && !pwrite && (paddr == svm_pkg::ADDR_CTRL);
  endsequence

  a_ctrl_upper_zero: assert property (
    s_ctrl_read |-> (prdata[31:6] == 26'h0))
    else $error("control read shows upper bits set");

  a_stable_only_settled: assert property (
    (s_ctrl_read and prdata[svm_pkg::STABLE_BIT])
      |-> $past(st.det == svm_pkg::DET_ACTIVE) && $past(st.power))
    else $error("stable flag read without settled detector");

  a_power_write: assert property (
    s_ctrl_write |-> ##2 (analog_ctl.det_power == $past(pwdata[4], 2)))
    else $error("power enable write did not reach the detector");

  a_level_write: assert property (
    s_ctrl_write |-> ##2 (analog_ctl.level == $past(pwdata[3:0], 2)))
    else $error("trip level write did not reach the divider");

  a_ext_route: assert property (
    $changed(analog_ctl.level)
      |-> analog_ctl.ext_sel == (analog_ctl.level == svm_pkg::LEVEL_EXT))
    else $error("external input routing disagrees with level");

  a_flag_settled: assert property (
    $rose(status[svm_pkg::LOW_BIT])
      |-> $past(st.det == svm_pkg::DET_ACTIVE) && $past(cmp_low))
    else $error("low voltage flag set before reference settled");

  a_settle_on_enable: assert property (
    st.det == svm_pkg::DET_OFF && st.power
      |=> st.det == svm_pkg::DET_SETTLE)
    else $error("enable did not start settling");

  a_ref_shared: assert property (
    !st.power && !bor_enable |=> !analog_ctl.ref_power)
    else $error("reference kept powered with no user");

  a_flag_sticky: assert property (
    status[svm_pkg::LOW_BIT] && !stat_clr |=> status[svm_pkg::LOW_BIT])
    else $error("low voltage flag dropped without a read");

  a_wake_sleep: assert property (
    sleep_mode && low_set && !status[svm_pkg::LOW_BIT]
      |=> wake_req && status[svm_pkg::WAKE_BIT])
    else $error("no wake on a trip during sleep");

  a_vector_gie: assert property (
    wake_req |-> (vector_branch == $past(st.global_irq_enable)))
    else $error("vector branch disagrees with global enable");

  a_power_off_path: assert property (
    !st.power |=> !analog_ctl.det_power)
    else $error("detector powered while disabled");

  // a cleared enable drops the power sequence at once
  a_det_off_state: assert property (
    !st.power |=> st.det == svm_pkg::DET_OFF)
    else $error("power sequence running while disabled");

  // a status read removes the flag it reported
  a_clear_on_read: assert property (
    stat_clr && st.rdata[svm_pkg::LOW_BIT] && !low_set |=> !status[svm_pkg::LOW_BIT])
    else $error("low voltage flag survived its read");

  // level interrupt follows the unmasked sticky bits
  a_irq_level: assert property (
    irq == $past(|(status & st.mask)))
    else $error("interrupt level disagrees with masked status");

  // unmapped addresses answer with an error
  a_slverr_unmapped: assert property (
    pready && psel && !mapped |-> pslverr)
    else $error("unmapped access answered without error");

  // a vector branch only comes with a wake
  a_vect_wake: assert property (
    vector_branch |-> wake_req)
    else $error("vector branch without wake");
endmodule : svm_monitor_ctrl
`default_nettype wire

// ### testbench/svm_analog_model.sv
// behavioural model of the analog comparator, divider and shared reference
`timescale 1ns/10ps
`default_nettype none
module svm_analog_model #(
  parameter int SETTLE_NS = 3000  // reference start-up, plain default
) (
  input  wire logic                        ref_on,
  input  wire svm_pkg::svm_analog_ctl_type ctl,
  input  wire logic                        supply_low,
  input  wire logic                        ext_low,
  output var  logic                        comparator_low,
  output var  logic                        reference_ready
);
  // start-up runs on time, not on the clock, so a slow bus sees the same delay
  initial reference_ready = 1'b0;
  always @(posedge ref_on) begin
    #(SETTLE_NS);
    if (ref_on) begin
      reference_ready = 1'b1;
    end
  end
  // losing both users drops the reference at once
  always @(negedge ref_on) begin
    reference_ready = 1'b0;
  end
  // unpowered comparator output is pulled low
  always_comb begin
    if (ctl.det_power && reference_ready) begin
      comparator_low = ctl.ext_sel ? ext_low : supply_low;
    end else begin
      comparator_low = 1'b0;
    end
  end
endmodule : svm_analog_model
`default_nettype wire

// ### testbench/tb_svm_monitor_ctrl.sv
// self-checking bench of the supply voltage monitor control
`timescale 1ns/10ps
`default_nettype none
module tb_svm_monitor_ctrl;
  logic                        pclk = 1'b0;
  logic                        presetn = 1'b0;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [7:0]                  paddr = 8'h00;
  logic [31:0]                 pwdata = 32'h0;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        comparator_low;
  logic                        reference_ready;
  logic                        bor_enable = 1'b0;
  logic                        sleep_mode = 1'b0;
  svm_pkg::svm_analog_ctl_type analog_ctl;
  logic                        irq;
  logic                        wake_req;
  logic                        vector_branch;
  logic                        supply_low = 1'b0;  // supply below selected trip
  logic                        ext_low = 1'b0;     // external input below trip
  logic [31:0]                 rd;                 // last read data
  logic                        er;                 // last error response
  int                          error_cnt = 0;
  int                          checks_done = 0;
  int                          wake_cnt = 0;       // wake pulses seen
  int                          vb_cnt = 0;         // vector pulses seen

  always #50 pclk = ~pclk;  // 10 MHz

  svm_monitor_ctrl i_svm_monitor_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_low(comparator_low),
    .reference_ready(reference_ready), .bor_enable(bor_enable),
    .sleep_mode(sleep_mode), .analog_ctl(analog_ctl), .irq(irq),
    .wake_req(wake_req), .vector_branch(vector_branch)
  );
  svm_analog_model i_svm_analog_model (
    .ref_on(analog_ctl.ref_power), .ctl(analog_ctl), .supply_low(supply_low),
    .ext_low(ext_low), .comparator_low(comparator_low),
    .reference_ready(reference_ready)
  );

  // pulses stand one cycle, so count them at every edge
  always @(posedge pclk) begin
    if (wake_req === 1'b1) begin
      wake_cnt++;
    end
    if (vector_branch === 1'b1) begin
      vb_cnt++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) chk(32'hDEAD, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read until any bit of m is set, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) === 32'h0 && n < 100);
  endtask : poll

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic t_reset_values;
    chk(32'(analog_ctl), 32'h05);
    apb(1'b0, svm_pkg::ADDR_CTRL, 32'h0); chk(rd, 32'h05);
    apb(1'b0, svm_pkg::ADDR_STATUS, 32'h0); chk(rd, 32'h0);
    apb(1'b0, svm_pkg::ADDR_MASK, 32'h0); chk(rd, 32'h0);
  endtask : t_reset_values

  // reserved top bits and read-only stable bit ignore writes
  task automatic t_ctrl_bits;
    apb(1'b1, svm_pkg::ADDR_CTRL, 32'hFF);
    apb(1'b0, svm_pkg::ADDR_CTRL, 32'h0); chk(rd, 32'h1F);
    chk({31'h0, analog_ctl.det_power}, 32'h1);
    apb(1'b1, svm_pkg::ADDR_CTRL, 32'h00);
    repeat (2) @(posedge pclk);
    chk({31'h0, analog_ctl.det_power}, 32'h0);
  endtask : t_ctrl_bits

  // every level code reaches the divider, only 1111 picks the pin
  task automatic t_levels;
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, svm_pkg::ADDR_CTRL, 32'(i));
      repeat (2) @(posedge pclk);
      chk({analog_ctl.ext_sel, analog_ctl.level}, {i == 15, 4'(i)});
    end
  endtask : t_levels

  task automatic t_settle;
    supply_low <= 1'b1;
    apb(1'b1, svm_pkg::ADDR_CTRL, 32'h1E);
    repeat (3) begin
      apb(1'b0, svm_pkg::ADDR_STATUS, 32'h0); chk(rd & 32'h1, 32'h0);
    end
    apb(1'b0, svm_pkg::ADDR_CTRL, 32'h0); chk(rd, 32'h1E);
    poll(svm_pkg::ADDR_CTRL, 32'h20); chk(rd, 32'h3E);
    poll(svm_pkg::ADDR_STATUS, 32'h1); chk(rd & 32'h1, 32'h1);
    supply_low <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, svm_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, svm_pkg::ADDR_STATUS, 32'h0); chk(rd, 32'h0);
    supply_low <= 1'b1;
    repeat (10) @(posedge pclk);
    supply_low <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, svm_pkg::ADDR_STATUS, 32'h0); chk(rd & 32'h1, 32'h1);
  endtask : t_settle

  // mask gates the level interrupt, a read clears it
  task automatic t_irq;
    apb(1'b1, svm_pkg::ADDR_MASK, 32'h1);
    apb(1'b0, svm_pkg::ADDR_MASK, 32'h0); chk(rd, 32'h1);
    supply_low <= 1'b1;
    repeat (10) @(posedge pclk);
    supply_low <= 1'b0;
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, svm_pkg::ADDR_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, svm_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, svm_pkg::ADDR_STATUS, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_irq

  // wake from sleep, with and without the global enable
  task automatic t_sleep(input logic g);
    apb(1'b1, svm_pkg::ADDR_GIE, {31'h0, g});
    sleep_mode <= 1'b1;
    wake_cnt = 0;
    vb_cnt = 0;
    supply_low <= 1'b1;
    repeat (10) @(posedge pclk);
    supply_low <= 1'b0;
    repeat (4) @(posedge pclk);
    sleep_mode <= 1'b0;
    chk(32'(wake_cnt), 32'h1);
    chk(32'(vb_cnt), {31'h0, g});
    apb(1'b0, svm_pkg::ADDR_STATUS, 32'h0); chk(rd, 32'h3);
  endtask : t_sleep

  // a second user keeps the reference alive, losing both restarts it
  task automatic t_shared_ref;
    bor_enable <= 1'b1;
    apb(1'b1, svm_pkg::ADDR_CTRL, 32'h0E);
    repeat (2) @(posedge pclk);
    chk({31'h0, analog_ctl.ref_power}, 32'h1);
    bor_enable <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b1, svm_pkg::ADDR_CTRL, 32'h1E);
    apb(1'b0, svm_pkg::ADDR_CTRL, 32'h0); chk(rd, 32'h1E);
  endtask : t_shared_ref

  task automatic t_unmapped;
    apb(1'b0, 8'h10, 32'h0); chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b0, svm_pkg::ADDR_CTRL, 32'h0); chk({31'h0, er}, 32'h0);
  endtask : t_unmapped

  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #(3_000_000);
    error_cnt++;
    report_and_stop;
  end

  initial begin
    do_reset;
    t_reset_values;
    t_ctrl_bits;
    t_levels;
    t_settle;
    t_irq;
    t_sleep(1'b0);
    t_sleep(1'b1);
    t_shared_ref;
    t_unmapped;
    do_reset;
    t_reset_values;
    report_and_stop;
  end
endmodule : tb_svm_monitor_ctrl
`default_nettype wire
